/* verilog/logic_cmp_pkg.sv */
// constants and types for the logical-and and compare-branch execute unit
package logic_cmp_pkg;
    // opcodes and match masks
    localparam logic [7:0] OP_AND_REG = 8'h58;
    localparam logic [7:0] OP_AND_IND = 8'h56;
    localparam logic [7:0] OP_AND_IMM = 8'h54;
    localparam logic [7:0] OP_AND_DIR = 8'h55;
    localparam logic [7:0] OP_AND_DIRA = 8'h52;
    localparam logic [7:0] OP_AND_DIRI = 8'h53;
    localparam logic [7:0] OP_ANC_BIT = 8'h82;
    localparam logic [7:0] OP_ANC_NBIT = 8'hb0;
    localparam logic [7:0] OP_CJ_IMM = 8'hb4;
    localparam logic [7:0] OP_CJ_DIR = 8'hb5;
    localparam logic [7:0] OP_CJ_IND = 8'hb6;
    localparam logic [7:0] OP_CJ_REG = 8'hb8;
    localparam logic [7:0] MASK_REG = 8'hf8;
    localparam logic [7:0] MASK_IND = 8'hfe;
    // operand read spaces
    localparam logic [1:0] K_REG = 2'h0;
    localparam logic [1:0] K_DIR = 2'h1;
    localparam logic [1:0] K_IND = 2'h2;
    localparam logic [1:0] K_BIT = 2'h3;
    // lengths, cycle counts, branch step
    localparam logic [1:0] LEN_1 = 2'h1;
    localparam logic [1:0] LEN_2 = 2'h2;
    localparam logic [1:0] LEN_3 = 2'h3;
    localparam logic [1:0] CYC_1 = 2'h1;
    localparam logic [1:0] CYC_2 = 2'h2;
    localparam logic [15:0] BR_STEP = 16'h0003;
    // reset values
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [15:0] RST_WORD = 16'h0000;
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_PTR = 2'b01,
        ST_OPND = 2'b11,
        ST_FIN = 2'b10
    } state_type;
    typedef enum logic [3:0] {
        C_NONE, C_AND_REG, C_AND_DIR, C_AND_IND, C_AND_IMM, C_AND_DIRA, C_AND_DIRI,
        C_ANC_BIT, C_ANC_NBIT, C_CJ_DIR, C_CJ_IMM, C_CJ_IND, C_CJ_REG
    } op_class_type;
endpackage

/* verilog/logic_cmp_exec.sv */
// execute unit for byte and carry logical-and and compare-branch-not-equal
// Behaviour
// - and working register into accumulator, 1 byte
// - and direct byte into accumulator, 2 bytes
// - and indirect ram byte into accumulator
// - and immediate byte into accumulator, 2 bytes
// - and accumulator into direct byte, written back
// - and immediate mask into direct byte, 3 bytes
// - zero bit clears carry, else carry kept
// - inverted bit used, source bit untouched
// - carry and: direct bit only, carry only
// - next address plus 3, add offset if unequal
// - carry set when first below second; operands kept
// - exactly four compare operand pairings
// - register compare: three bytes, two cycles
// - accumulator immediate compare: three bytes, two cycles
// - byte and changes no status flag
// - read-modify-write reads port output latch
module logic_cmp_exec (
    input wire logic mclk,
    input wire logic rstn,
    input wire logic start,
    input wire logic [7:0] opcode,
    input wire logic [7:0] byte2,
    input wire logic [7:0] byte3,
    input wire logic [15:0] program_counter,
    input wire logic [7:0] accum_in,
    input wire logic carry_in,
    input wire logic [7:0] rd_data,
    output logic busy_r,
    output logic rd_req_r,
    output logic [1:0] rd_kind_r,
    output logic [7:0] rd_addr_r,
    output logic rd_latch_r,
    output logic done_r,
    output logic illegal_r,
    output logic [1:0] len_r,
    output logic [1:0] cyc_r,
    output logic accum_we_r,
    output logic [7:0] accum_wdata_r,
    output logic wr_req_r,
    output logic [7:0] wr_addr_r,
    output logic [7:0] wr_data_r,
    output logic carry_we_r,
    output logic carry_wdata_r,
    output logic pc_we_r,
    output logic [15:0] pc_wdata_r
);

////////////////////////////////////////////////////////////////////////////////
// opcode decode
function automatic logic_cmp_pkg::op_class_type decode(input logic [7:0] op);
    logic_cmp_pkg::op_class_type c;
    c = logic_cmp_pkg::C_NONE;
    if ((op & logic_cmp_pkg::MASK_REG) == logic_cmp_pkg::OP_AND_REG) begin
        c = logic_cmp_pkg::C_AND_REG;
    end else if ((op & logic_cmp_pkg::MASK_IND) == logic_cmp_pkg::OP_AND_IND) begin
        c = logic_cmp_pkg::C_AND_IND;
    end else if (op == logic_cmp_pkg::OP_AND_IMM) begin
        c = logic_cmp_pkg::C_AND_IMM;
    end else if (op == logic_cmp_pkg::OP_AND_DIR) begin
        c = logic_cmp_pkg::C_AND_DIR;
    end else if (op == logic_cmp_pkg::OP_AND_DIRA) begin
        c = logic_cmp_pkg::C_AND_DIRA;
    end else if (op == logic_cmp_pkg::OP_AND_DIRI) begin
        c = logic_cmp_pkg::C_AND_DIRI;
    end else if (op == logic_cmp_pkg::OP_ANC_BIT) begin
        c = logic_cmp_pkg::C_ANC_BIT;
    end else if (op == logic_cmp_pkg::OP_ANC_NBIT) begin
        c = logic_cmp_pkg::C_ANC_NBIT;
    end else if (op == logic_cmp_pkg::OP_CJ_DIR) begin
        c = logic_cmp_pkg::C_CJ_DIR;
    end else if (op == logic_cmp_pkg::OP_CJ_IMM) begin
        c = logic_cmp_pkg::C_CJ_IMM;
    end else if ((op & logic_cmp_pkg::MASK_IND) == logic_cmp_pkg::OP_CJ_IND) begin
        c = logic_cmp_pkg::C_CJ_IND;
    end else if ((op & logic_cmp_pkg::MASK_REG) == logic_cmp_pkg::OP_CJ_REG) begin
        c = logic_cmp_pkg::C_CJ_REG;
    end
    return c;
endfunction

////////////////////////////////////////////////////////////////////////////////
// state
logic_cmp_pkg::state_type state_r, state_nxt;
logic_cmp_pkg::op_class_type cls_r, cls_nxt, cls_in;
logic [7:0] op_r, op_nxt, b2_r, b2_nxt, b3_r, b3_nxt;
logic [15:0] pc_r, pc_nxt;
logic busy_nxt, rd_req_nxt, rd_latch_nxt, done_nxt, illegal_nxt;
logic [1:0] rd_kind_nxt, len_nxt, cyc_nxt;
logic [7:0] rd_addr_nxt;
logic accum_we_nxt, wr_req_nxt, carry_we_nxt, carry_wdata_nxt, pc_we_nxt;
logic [7:0] accum_wdata_nxt, wr_addr_nxt, wr_data_nxt;
logic [15:0] pc_wdata_nxt;
logic [7:0] cmp_a, cmp_b;
logic [15:0] seq_pc, br_pc;
logic is_cj;

assign cls_in = decode(opcode);
assign is_cj = (cls_r == logic_cmp_pkg::C_CJ_DIR) || (cls_r == logic_cmp_pkg::C_CJ_IMM) ||
               (cls_r == logic_cmp_pkg::C_CJ_IND) || (cls_r == logic_cmp_pkg::C_CJ_REG);
// compare operands; neither is written back
assign cmp_a = ((cls_r == logic_cmp_pkg::C_CJ_DIR) || (cls_r == logic_cmp_pkg::C_CJ_IMM)) ?
               accum_in : rd_data;
assign cmp_b = (cls_r == logic_cmp_pkg::C_CJ_DIR) ? rd_data : b2_r;
assign seq_pc = pc_r + logic_cmp_pkg::BR_STEP;
assign br_pc = seq_pc + {{8{b3_r[7]}}, b3_r};

////////////////////////////////////////////////////////////////////////////////
// next-state logic
always_comb begin
    state_nxt = state_r;
    cls_nxt = cls_r;
    op_nxt = op_r;
    b2_nxt = b2_r;
    b3_nxt = b3_r;
    pc_nxt = pc_r;
    busy_nxt = busy_r;
    rd_req_nxt = 1'b0;
    rd_kind_nxt = rd_kind_r;
    rd_addr_nxt = rd_addr_r;
    rd_latch_nxt = 1'b0;
    done_nxt = 1'b0;
    illegal_nxt = 1'b0;
    len_nxt = len_r;
    cyc_nxt = cyc_r;
    accum_we_nxt = 1'b0;
    accum_wdata_nxt = accum_wdata_r;
    wr_req_nxt = 1'b0;
    wr_addr_nxt = wr_addr_r;
    wr_data_nxt = wr_data_r;
    carry_we_nxt = 1'b0;
    carry_wdata_nxt = carry_wdata_r;
    pc_we_nxt = 1'b0;
    pc_wdata_nxt = pc_wdata_r;
    case (state_r)
        logic_cmp_pkg::ST_IDLE: begin
            if (start) begin
                cls_nxt = cls_in;
                op_nxt = opcode;
                b2_nxt = byte2;
                b3_nxt = byte3;
                pc_nxt = program_counter;
                busy_nxt = 1'b1;
                state_nxt = logic_cmp_pkg::ST_OPND;
                case (cls_in)
                    logic_cmp_pkg::C_AND_REG, logic_cmp_pkg::C_CJ_REG: begin
                        rd_req_nxt = 1'b1;
                        rd_kind_nxt = logic_cmp_pkg::K_REG;
                        rd_addr_nxt = {5'h00, opcode[2:0]};
                    end
                    logic_cmp_pkg::C_AND_IND, logic_cmp_pkg::C_CJ_IND: begin
                        // pointer register first, then the ram byte
                        rd_req_nxt = 1'b1;
                        rd_kind_nxt = logic_cmp_pkg::K_REG;
                        rd_addr_nxt = {7'h00, opcode[0]};
                        state_nxt = logic_cmp_pkg::ST_PTR;
                    end
                    logic_cmp_pkg::C_AND_DIR, logic_cmp_pkg::C_CJ_DIR: begin
                        rd_req_nxt = 1'b1;
                        rd_kind_nxt = logic_cmp_pkg::K_DIR;
                        rd_addr_nxt = byte2;
                    end
                    logic_cmp_pkg::C_AND_DIRA, logic_cmp_pkg::C_AND_DIRI: begin
                        rd_req_nxt = 1'b1;
                        rd_kind_nxt = logic_cmp_pkg::K_DIR;
                        rd_addr_nxt = byte2;
                        rd_latch_nxt = 1'b1;
                    end
                    logic_cmp_pkg::C_ANC_BIT, logic_cmp_pkg::C_ANC_NBIT: begin
                        rd_req_nxt = 1'b1;
                        rd_kind_nxt = logic_cmp_pkg::K_BIT;
                        rd_addr_nxt = byte2;
                    end
                    default: begin
                        rd_req_nxt = 1'b0;
                    end
                endcase
            end
        end
        logic_cmp_pkg::ST_PTR: begin
            rd_req_nxt = 1'b1;
            rd_kind_nxt = logic_cmp_pkg::K_IND;
            rd_addr_nxt = rd_data;
            state_nxt = logic_cmp_pkg::ST_OPND;
        end
        logic_cmp_pkg::ST_OPND: begin
            done_nxt = 1'b1;
            state_nxt = logic_cmp_pkg::ST_FIN;
            len_nxt = logic_cmp_pkg::LEN_1;
            cyc_nxt = logic_cmp_pkg::CYC_1;
            // byte and forms touch no status flag
            case (cls_r)
                logic_cmp_pkg::C_AND_REG, logic_cmp_pkg::C_AND_IND: begin
                    accum_we_nxt = 1'b1;
                    accum_wdata_nxt = accum_in & rd_data;
                end
                logic_cmp_pkg::C_AND_DIR: begin
                    len_nxt = logic_cmp_pkg::LEN_2;
                    accum_we_nxt = 1'b1;
                    accum_wdata_nxt = accum_in & rd_data;
                end
                logic_cmp_pkg::C_AND_IMM: begin
                    len_nxt = logic_cmp_pkg::LEN_2;
                    accum_we_nxt = 1'b1;
                    accum_wdata_nxt = accum_in & b2_r;
                end
                logic_cmp_pkg::C_AND_DIRA: begin
                    len_nxt = logic_cmp_pkg::LEN_2;
                    wr_req_nxt = 1'b1;
                    wr_addr_nxt = b2_r;
                    wr_data_nxt = rd_data & accum_in;
                end
                logic_cmp_pkg::C_AND_DIRI: begin
                    len_nxt = logic_cmp_pkg::LEN_3;
                    cyc_nxt = logic_cmp_pkg::CYC_2;
                    wr_req_nxt = 1'b1;
                    wr_addr_nxt = b2_r;
                    wr_data_nxt = rd_data & b3_r;
                end
                logic_cmp_pkg::C_ANC_BIT, logic_cmp_pkg::C_ANC_NBIT: begin
                    len_nxt = logic_cmp_pkg::LEN_2;
                    cyc_nxt = logic_cmp_pkg::CYC_2;
                    // a zero bit (a one bit for the inverted form) clears carry; the bit is never written
                    carry_we_nxt = (cls_r == logic_cmp_pkg::C_ANC_NBIT) ?
                                   rd_data[0] : ~rd_data[0];
                    carry_wdata_nxt = 1'b0;
                end
                logic_cmp_pkg::C_CJ_DIR, logic_cmp_pkg::C_CJ_IMM,
                logic_cmp_pkg::C_CJ_IND, logic_cmp_pkg::C_CJ_REG: begin
                    len_nxt = logic_cmp_pkg::LEN_3;
                    cyc_nxt = logic_cmp_pkg::CYC_2;
                    carry_we_nxt = 1'b1;
                    carry_wdata_nxt = cmp_a < cmp_b;
                    pc_we_nxt = 1'b1;
                    pc_wdata_nxt = (cmp_a != cmp_b) ? br_pc : seq_pc;
                end
                default: begin
                    illegal_nxt = 1'b1;
                end
            endcase
        end
        logic_cmp_pkg::ST_FIN: begin
            busy_nxt = 1'b0;
            state_nxt = logic_cmp_pkg::ST_IDLE;
        end
        default: begin
            state_nxt = logic_cmp_pkg::ST_IDLE;
        end
    endcase
end

////////////////////////////////////////////////////////////////////////////////
// registers
always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
        state_r <= logic_cmp_pkg::ST_IDLE;
        cls_r <= logic_cmp_pkg::C_NONE;
        op_r <= logic_cmp_pkg::RST_BYTE;
        b2_r <= logic_cmp_pkg::RST_BYTE;
        b3_r <= logic_cmp_pkg::RST_BYTE;
        pc_r <= logic_cmp_pkg::RST_WORD;
        busy_r <= 1'b0;
        rd_req_r <= 1'b0;
        rd_kind_r <= logic_cmp_pkg::K_REG;
        rd_addr_r <= logic_cmp_pkg::RST_BYTE;
        rd_latch_r <= 1'b0;
        done_r <= 1'b0;
        illegal_r <= 1'b0;
        len_r <= logic_cmp_pkg::LEN_1;
        cyc_r <= logic_cmp_pkg::CYC_1;
        accum_we_r <= 1'b0;
        accum_wdata_r <= logic_cmp_pkg::RST_BYTE;
        wr_req_r <= 1'b0;
        wr_addr_r <= logic_cmp_pkg::RST_BYTE;
        wr_data_r <= logic_cmp_pkg::RST_BYTE;
        carry_we_r <= 1'b0;
        carry_wdata_r <= 1'b0;
        pc_we_r <= 1'b0;
        pc_wdata_r <= logic_cmp_pkg::RST_WORD;
    end else begin
        state_r <= state_nxt;
        cls_r <= cls_nxt;
        op_r <= op_nxt;
        b2_r <= b2_nxt;
        b3_r <= b3_nxt;
        pc_r <= pc_nxt;
        busy_r <= busy_nxt;
        rd_req_r <= rd_req_nxt;
        rd_kind_r <= rd_kind_nxt;
        rd_addr_r <= rd_addr_nxt;
        rd_latch_r <= rd_latch_nxt;
        done_r <= done_nxt;
        illegal_r <= illegal_nxt;
        len_r <= len_nxt;
        cyc_r <= cyc_nxt;
        accum_we_r <= accum_we_nxt;
        accum_wdata_r <= accum_wdata_nxt;
        wr_req_r <= wr_req_nxt;
        wr_addr_r <= wr_addr_nxt;
        wr_data_r <= wr_data_nxt;
        carry_we_r <= carry_we_nxt;
        carry_wdata_r <= carry_wdata_nxt;
        pc_we_r <= pc_we_nxt;
        pc_wdata_r <= pc_wdata_nxt;
    end
end

////////////////////////////////////////////////////////////////////////////////
// checks
and_reg_a: assert property (@(posedge mclk) disable iff (!rstn)
    (state_r == logic_cmp_pkg::ST_OPND && cls_r == logic_cmp_pkg::C_AND_REG) |=>
    (accum_we_r && accum_wdata_r == ($past(accum_in) & $past(rd_data)) && len_r == 2'h1))
    else $error("register and result wrong");
and_dir_rd_a: assert property (@(posedge mclk) disable iff (!rstn)
    (state_r == logic_cmp_pkg::ST_OPND && cls_r == logic_cmp_pkg::C_AND_DIR) |->
    (rd_req_r && rd_kind_r == logic_cmp_pkg::K_DIR && rd_addr_r == b2_r))
    else $error("direct operand read wrong");
ind_ptr_a: assert property (@(posedge mclk) disable iff (!rstn)
    (state_r == logic_cmp_pkg::ST_PTR) |=>
    (rd_req_r && rd_kind_r == logic_cmp_pkg::K_IND && rd_addr_r == $past(rd_data)))
    else $error("indirect address not from pointer");
and_imm_a: assert property (@(posedge mclk) disable iff (!rstn)
    (state_r == logic_cmp_pkg::ST_OPND && cls_r == logic_cmp_pkg::C_AND_IMM) |=>
    (accum_wdata_r == ($past(accum_in) & $past(b2_r)) && !wr_req_r && len_r == 2'h2))
    else $error("immediate and result wrong");
and_into_dir_a: assert property (@(posedge mclk) disable iff (!rstn)
    (state_r == logic_cmp_pkg::ST_OPND && cls_r == logic_cmp_pkg::C_AND_DIRA) |->
    rd_latch_r ##1 (wr_req_r && wr_addr_r == $past(b2_r) && !accum_we_r))
    else $error("and into direct byte wrong");
mask_len_a: assert property (@(posedge mclk) disable iff (!rstn)
    (done_r && cls_r == logic_cmp_pkg::C_AND_DIRI) |-> (len_r == 2'h3 && cyc_r == 2'h2))
    else $error("mask form length wrong");
carry_keep_a: assert property (@(posedge mclk) disable iff (!rstn)
    (state_r == logic_cmp_pkg::ST_OPND && cls_r == logic_cmp_pkg::C_ANC_BIT && rd_data[0])
    |=> !carry_we_r)
    else $error("carry changed by one bit");
carry_inv_a: assert property (@(posedge mclk) disable iff (!rstn)
    (state_r == logic_cmp_pkg::ST_OPND && cls_r == logic_cmp_pkg::C_ANC_NBIT && rd_data[0])
    |=> (carry_we_r && !carry_wdata_r && !wr_req_r))
    else $error("inverted bit and wrong");
no_flag_a: assert property (@(posedge mclk) disable iff (!rstn)
    (done_r && !is_cj && cls_r != logic_cmp_pkg::C_ANC_BIT &&
    cls_r != logic_cmp_pkg::C_ANC_NBIT) |-> (!carry_we_r && !pc_we_r))
    else $error("byte and touched a flag");
cj_target_a: assert property (@(posedge mclk) disable iff (!rstn)
    (done_r && is_cj) |-> (pc_we_r && (pc_wdata_r == pc_r + 16'h0003 ||
    pc_wdata_r == pc_r + 16'h0003 + {{8{b3_r[7]}}, b3_r})))
    else $error("branch target wrong");
cj_carry_a: assert property (@(posedge mclk) disable iff (!rstn)
    (state_r == logic_cmp_pkg::ST_OPND && is_cj) |=>
    (carry_we_r && carry_wdata_r == ($past(cmp_a) < $past(cmp_b)) && !wr_req_r && !accum_we_r))
    else $error("compare carry wrong");

endmodule

/* tb/logic_cmp_exec_test.sv */
// self-checking bench for the logical-and and compare-branch execute unit
module logic_cmp_exec_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic mclk, rstn, start, carry_in, busy_r, rd_req_r, rd_latch_r, done_r, illegal_r;
    logic [7:0] opcode, byte2, byte3, accum_in, rd_data, rd_addr_r, accum_wdata_r;
    logic [7:0] wr_addr_r, wr_data_r;
    logic [15:0] program_counter, pc_wdata_r;
    logic [1:0] rd_kind_r, len_r, cyc_r;
    logic accum_we_r, wr_req_r, carry_we_r, carry_wdata_r, pc_we_r, latch_seen;
    logic [7:0] regs [8];
    logic [7:0] ram [256];
    logic [7:0] ops [16] = '{8'h58, 8'h5b, 8'h5f, 8'h56, 8'h57, 8'h55, 8'h54, 8'h52,
                             8'h53, 8'h82, 8'hb0, 8'hb4, 8'hb5, 8'hb6, 8'hb7, 8'hbd};
    logic e_ill, e_awe, e_wr, e_cwe, e_cwd, e_pwe;
    logic [1:0] e_len, e_cyc;
    logic [7:0] e_acc, e_wa, e_wd;
    logic [15:0] e_pc;
    int e_lat, miscompares, tests_run, cycles;
    ////////////////////////////////////////////////////////////////////////////////
    logic_cmp_exec u_logic_cmp_exec (.mclk(mclk), .rstn(rstn), .start(start), .opcode(opcode),
        .byte2(byte2), .byte3(byte3), .program_counter(program_counter), .accum_in(accum_in),
        .carry_in(carry_in), .rd_data(rd_data), .busy_r(busy_r), .rd_req_r(rd_req_r),
        .rd_kind_r(rd_kind_r), .rd_addr_r(rd_addr_r), .rd_latch_r(rd_latch_r),
        .done_r(done_r), .illegal_r(illegal_r), .len_r(len_r), .cyc_r(cyc_r),
        .accum_we_r(accum_we_r), .accum_wdata_r(accum_wdata_r), .wr_req_r(wr_req_r),
        .wr_addr_r(wr_addr_r), .wr_data_r(wr_data_r), .carry_we_r(carry_we_r),
        .carry_wdata_r(carry_wdata_r), .pc_we_r(pc_we_r), .pc_wdata_r(pc_wdata_r));
    // read answer; unrequested reads see inverted data
    assign rd_data = !rd_req_r ? ~ram[rd_addr_r] :
                     (rd_kind_r == 2'h0) ? regs[rd_addr_r[2:0]] : ram[rd_addr_r];
    // latch-read flag, cleared when an instruction is taken
    always @(posedge mclk) begin
        if (rd_req_r === 1'b1 && rd_kind_r === 2'h1 && rd_latch_r === 1'b1)
            latch_seen <= 1'b1;
        else if (start === 1'b1 && busy_r === 1'b0)
            latch_seen <= 1'b0;
    end
    initial begin
        mclk = 1'b0;
        forever #12.5 mclk = ~mclk;
    end
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 20000) begin
            miscompares++;
            close_out();
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        tests_run++;
        if (seen !== exp) begin
            miscompares++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic close_out();
        $display("comparisons %0d mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    // expected outcome from the live operands
    task automatic predict(input logic [7:0] op, input logic [7:0] b2, input logic [7:0] b3);
        logic [7:0] a, b;
        {e_ill, e_awe, e_wr, e_cwe, e_cwd, e_pwe} = 6'h00;
        e_len = 2'h2;
        e_cyc = 2'h1;
        e_lat = 1;
        if (op == 8'hb4 || op == 8'hb5 || op[7:1] == 7'h5b || op[7:3] == 5'h17) begin
            a = op[3] ? regs[op[2:0]] : op[1] ? ram[regs[{2'h0, op[0]}]] : accum_in;
            b = (op == 8'hb5) ? ram[b2] : b2;
            e_lat = (op[1] && !op[3]) ? 2 : 1;
            {e_len, e_cyc, e_cwe, e_pwe} = {2'h3, 2'h2, 2'h3};
            e_cwd = a < b;
            e_pc = program_counter + 16'h0003 + ((a != b) ? {{8{b3[7]}}, b3} : 16'h0000);
        end else if (op[7:3] == 5'h0b) begin
            {e_awe, e_len, e_acc} = {1'b1, 2'h1, accum_in & regs[op[2:0]]};
        end else if (op[7:1] == 7'h2b) begin
            {e_awe, e_len, e_acc} = {1'b1, 2'h1, accum_in & ram[regs[{2'h0, op[0]}]]};
            e_lat = 2;
        end else begin
            case (op)
                8'h55: {e_awe, e_acc} = {1'b1, accum_in & ram[b2]};
                8'h54: {e_awe, e_acc} = {1'b1, accum_in & b2};
                8'h52: {e_wr, e_wa, e_wd} = {1'b1, b2, ram[b2] & accum_in};
                8'h53: {e_wr, e_wa, e_wd, e_len, e_cyc} = {1'b1, b2, ram[b2] & b3, 4'he};
                8'h82: {e_cwe, e_cyc} = {~ram[b2][0], 2'h2};
                8'hb0: {e_cwe, e_cyc} = {ram[b2][0], 2'h2};
                default: e_ill = 1'b1;
            endcase
        end
    endtask
    // one instruction; mode[0] forces equal compare, mode[1] puts pc at wrap
    task automatic run_op(input logic [7:0] op, input logic [7:0] b2, input logic [7:0] b3,
                          input logic [1:0] mode, input bit poke);
        int n;
        @(posedge mclk);
        #2;
        for (int i = 0; i < 256; i++)
            ram[i] = 8'($urandom);
        for (int i = 0; i < 8; i++)
            regs[i] = 8'($urandom);
        accum_in = 8'($urandom);
        carry_in = 1'($urandom);
        program_counter = mode[1] ? 16'hfffe : 16'($urandom);
        if (mode[0]) begin
            if (op == 8'hb4)
                b2 = accum_in;
            else if (op == 8'hb5)
                ram[b2] = accum_in;
            else if (op[3])
                b2 = regs[op[2:0]];
            else
                b2 = ram[regs[{2'h0, op[0]}]];
        end
        {opcode, byte2, byte3, start} = {op, b2, b3, 1'b1};
        predict(op, b2, b3);
        @(posedge mclk);
        #2;
        // a poke keeps start up until done; it must be ignored
        {start, opcode, byte2, byte3} = {poke, 24'($urandom)};
        n = 0;
        while (n < 8) begin
            @(posedge mclk);
            n++;
            #1;
            if (done_r === 1'b1)
                break;
            #1;
            start = poke && n == 1;
        end
        #1;
        start = 1'b0;
        check(16'(n), 16'(e_lat));
        check(illegal_r, e_ill);
        check(accum_we_r, e_awe);
        if (e_awe)
            check(accum_wdata_r, e_acc);
        check(wr_req_r, e_wr);
        if (e_wr)
            check({wr_addr_r, wr_data_r}, {e_wa, e_wd});
        check(carry_we_r, e_cwe);
        if (e_cwe)
            check(carry_wdata_r, e_cwd);
        check(pc_we_r, e_pwe);
        if (e_pwe)
            check(pc_wdata_r, e_pc);
        if (!e_ill)
            check({len_r, cyc_r}, {e_len, e_cyc});
        check(latch_seen, op == 8'h52 || op == 8'h53);
        repeat (poke ? 4 : 1) begin
            @(posedge mclk);
            #1;
            check(done_r, 1'b0);
        end
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        void'($urandom(2086));
        {rstn, start, carry_in, opcode, byte2, byte3, accum_in} = 35'h0;
        program_counter = 16'h0000;
        repeat (12) @(posedge mclk);
        #2;
        rstn = 1'b1;
        check({done_r, busy_r, len_r, cyc_r}, 6'h05);
        for (int i = 0; i < 256; i++)
            run_op(8'(i), 8'($urandom), 8'($urandom), 2'h0, i % 16 == 0);
        for (int i = 0; i < 400; i++)
            run_op(ops[4'($urandom)], 8'($urandom), 8'($urandom), 2'h0, 1'b0);
        for (int i = 11; i < 16; i++)
            for (int m = 0; m < 4; m++) begin
                run_op(ops[i], 8'($urandom), 8'h80, 2'(m), 1'b0);
                run_op(ops[i], 8'($urandom), 8'h7f, 2'(m), 1'b0);
            end
        // reset in mid-instruction abandons it
        @(posedge mclk);
        #2;
        {opcode, byte2, start} = {8'hb6, 8'h10, 1'b1};
        @(posedge mclk);
        #2;
        {start, rstn} = 2'b00;
        #1;
        check({busy_r, done_r, pc_we_r}, 3'h0);
        repeat (2) @(posedge mclk);
        #2;
        rstn = 1'b1;
        run_op(8'h53, 8'h20, 8'h73, 2'h0, 1'b0);
        close_out();
    end
endmodule
